// ### src/rtcc_irq_square_wave_out_trim.sv
`timescale 1ns/100ps
module rtcc_irq_square_wave_out_trim
    import rtcc_pkg::*;
#(
    parameter int HALF_CYC = HALF_XTAL_CYC
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    output logic      [7:0] regRdData,
    input  wire logic       alarmMatch,
    input  wire logic       countdownExpire,
    output logic            countdownRepeat,
    output logic            secondTick,
    input  wire logic       squareWaveGatePin,
    output logic            squareWaveOut,
    output logic            irqPinOut,
    output logic            irqPinOe
);
    initial begin
        if (HALF_CYC < 2 || HALF_CYC > 4095) $error("HALF_CYC out of range");
    end

    typedef struct packed {
        logic [11:0]         divCnt;
        logic                oscPh;
        logic [PRE_BITS-1:0] pre;
        logic [5:0]          sec;
        logic [6:0]          min;
        logic                secTick;
        logic                stopBit;
        logic                correction_irq_enable;
        logic                alarm_irq_enable;
        logic                af;
        logic                mi;
        logic                half_minute_irq_enable;
        logic                tf;
        logic [2:0]          cof;
        logic [7:0]          trim;
        logic                tie;
        logic                tiTp;
        logic [6:0]          corrLeft;
        logic                corrReq;
        logic [10:0]         corrPulse;
        logic [9:0]          perPulse;
        logic [7:0]          rdData;
        logic                sqOut;
        logic                irqOe;
        logic                cdRepeat;
    } rtcc_state_type;

    rtcc_state_type st_r;
    rtcc_state_type st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Combinational helpers
    logic        oscTick;
    logic        fastMode;
    logic [6:0]  trimMag;
    logic [15:0] preSum;
    logic [15:0] stepSize;
    logic        applyNow;
    logic        burstSlot;
    logic [9:0]  indWidth;
    logic        periodicEv;
    logic        timerReq;
    logic        corrReqLvl;
    logic        irqReq;
    logic        clkSel;

    // Crystal tick from the divider; one system cycle wide
    assign oscTick  = (st_r.divCnt == 12'(HALF_CYC - 1)) && !st_r.oscPh;
    assign fastMode = st_r.trim[TRIM_MODE_BIT];
    assign trimMag  = st_r.trim[6] ? 7'(~st_r.trim[6:0] + 7'h01) : st_r.trim[6:0];
    // Fast step sits low enough to move the 64 Hz stage as well
    assign stepSize = fastMode ? STEP_FAST : STEP_NORMAL;
    assign indWidth = fastMode ? IND_FAST_TICKS : IND_NORMAL_TICKS;
    // Extra pulses in second 59 wait for the previous indication to finish
    assign burstSlot = fastMode && (st_r.sec == SEC_LAST) && (st_r.corrPulse == 11'h000)
                     && (st_r.corrLeft != 7'h00);
    assign applyNow  = oscTick && (st_r.corrReq || burstSlot);

    // Prescaler step: a correction adds or drops one step above the split point
    always_comb begin
        preSum = {1'b0, st_r.pre} + 16'h0001;
        if (applyNow) begin
            preSum = st_r.trim[6] ? preSum - stepSize : preSum + stepSize;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_nxt       = st_r;
        st_nxt.secTick = 1'b0;
        periodicEv   = 1'b0;

        // Crystal half-period divider
        if (st_r.divCnt == 12'(HALF_CYC - 1)) begin
            st_nxt.divCnt = 12'h000;
            st_nxt.oscPh  = ~st_r.oscPh;
        end else begin
            st_nxt.divCnt = st_r.divCnt + 12'h001;
        end

        // Prescaler; stop clears the upper stages only
        if (oscTick) begin
            st_nxt.pre = preSum[PRE_BITS-1:0];
            if (st_r.pre[PRE_BITS-1] && !preSum[PRE_BITS-1]) begin
                st_nxt.secTick = 1'b1;
            end
        end
        if (st_r.stopBit) begin
            st_nxt.pre[PRE_BITS-1:2] = '0;
            st_nxt.secTick           = 1'b0;
        end

        // Seconds and two-hour minute window
        if (st_nxt.secTick) begin
            if (st_r.sec == SEC_LAST) begin
                st_nxt.sec = 6'h00;
                st_nxt.min = (st_r.min == MIN_LAST) ? 7'h00 : st_r.min + 7'h01;
            end else begin
                st_nxt.sec = st_r.sec + 6'h01;
            end
        end

        // Correction scheduler, runs on the cycle after the tick
        if (st_r.secTick) begin
            if (!fastMode) begin
                if (st_r.sec == 6'h00) begin
                    // Load at minute 00 of an even hour, then one per minute
                    if (st_r.min == 7'h00) begin
                        st_nxt.corrLeft = trimMag;
                        st_nxt.corrReq  = (trimMag != 7'h00);
                    end else begin
                        st_nxt.corrReq  = (st_r.corrLeft != 7'h00);
                    end
                end
            end else begin
                // Load every fourth minute, one per second
                if (st_r.sec == 6'h00 && st_r.min[1:0] == 2'h0) begin
                    st_nxt.corrLeft = trimMag;
                    st_nxt.corrReq  = (trimMag != 7'h00);
                end else begin
                    st_nxt.corrReq  = (st_r.corrLeft != 7'h00);
                end
            end
        end
        if (applyNow) begin
            st_nxt.corrReq   = 1'b0;
            st_nxt.corrLeft  = st_nxt.corrLeft - 7'h01;
            st_nxt.corrPulse = {indWidth, 1'b0};    // Width high, then width low gap
        end else if (oscTick && st_r.corrPulse != 11'h000) begin
            st_nxt.corrPulse = st_r.corrPulse - 11'h001;
        end

        // Minute and half-minute events from the seconds counter
        if (st_r.secTick) begin
            periodicEv = (st_r.mi && st_r.sec == 6'h00)
                       || (st_r.half_minute_irq_enable && (st_r.sec == 6'h00 || st_r.sec == SEC_HALF));
        end
        if (periodicEv || countdownExpire) begin
            st_nxt.perPulse = IND_NORMAL_TICKS;
        end else if (oscTick && st_r.perPulse != 10'h000) begin
            st_nxt.perPulse = st_r.perPulse - 10'h001;
        end

        // Register writes; flags AND with written bits
        if (regWrEn) begin
            unique case (regAddr)
                ADDR_CTRL1: begin
                    st_nxt.stopBit = regWrData[CTRL1_STOP_BIT];
                    st_nxt.correction_irq_enable     = regWrData[CTRL1_CIE_BIT];
                end
                ADDR_CTRL2: begin
                    st_nxt.alarm_irq_enable = regWrData[CTRL2_AIE_BIT];
                    st_nxt.af  = st_r.af & regWrData[CTRL2_AF_BIT];
                    st_nxt.mi  = regWrData[CTRL2_MI_BIT];
                    st_nxt.half_minute_irq_enable = regWrData[CTRL2_HMI_BIT];
                    st_nxt.tf  = st_r.tf & regWrData[CTRL2_TF_BIT];
                    st_nxt.cof = regWrData[2:0];
                end
                ADDR_TRIM: begin
                    st_nxt.trim = regWrData;
                end
                ADDR_TMODE: begin
                    st_nxt.tie  = regWrData[TMODE_TIE_BIT];
                    st_nxt.tiTp = regWrData[TMODE_TP_BIT];
                end
                default: begin
                end
            endcase
        end

        // Hardware set wins over a clearing write in the same cycle
        if (alarmMatch) begin
            st_nxt.af = 1'b1;
        end
        if (periodicEv || countdownExpire) begin
            st_nxt.tf = 1'b1;
        end

        // Registered read data
        unique case (regAddr)
            ADDR_CTRL1: st_nxt.rdData = {2'h0, st_r.stopBit, 2'h0, st_r.correction_irq_enable, 2'h0};
            ADDR_CTRL2: st_nxt.rdData = {st_r.alarm_irq_enable, st_r.af, st_r.mi, st_r.half_minute_irq_enable, st_r.tf, st_r.cof};
            ADDR_TRIM:  st_nxt.rdData = st_r.trim;
            ADDR_TMODE: st_nxt.rdData = {6'h00, st_r.tie, st_r.tiTp};
            default:    st_nxt.rdData = 8'h00;
        endcase

        // Clock-out mux; prescaler bits give 50:50 duty below 32768 Hz
        unique case (st_r.cof)
            COF_32768: clkSel = st_r.oscPh;
            COF_16384: clkSel = st_r.pre[0];
            COF_8192:  clkSel = st_r.pre[1];
            COF_4096:  clkSel = st_r.pre[2] & ~st_r.stopBit;
            COF_2048:  clkSel = st_r.pre[3] & ~st_r.stopBit;
            COF_1024:  clkSel = st_r.pre[4] & ~st_r.stopBit;
            COF_1HZ:   clkSel = st_r.pre[PRE_BITS-1] & ~st_r.stopBit;
            COF_OFF:   clkSel = 1'b0;
        endcase
        st_nxt.sqOut = clkSel & squareWaveGatePin;

        // Interrupt sources
        timerReq   = st_r.tiTp ? (st_r.perPulse != 10'h000)
                               : (st_r.tf && (st_r.mi || st_r.half_minute_irq_enable || st_r.tie));
        corrReqLvl = st_r.correction_irq_enable && (st_r.corrPulse > {1'b0, indWidth});
        irqReq     = (st_r.alarm_irq_enable && st_r.af) || timerReq || corrReqLvl;
        st_nxt.irqOe    = irqReq;
        st_nxt.cdRepeat = st_r.tiTp;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_r          <= '0;
            st_r.stopBit  <= RST_CTRL1[CTRL1_STOP_BIT];
            st_r.correction_irq_enable      <= RST_CTRL1[CTRL1_CIE_BIT];
            st_r.cof      <= RST_CTRL2[2:0];                // Output enabled at 32768 Hz
            st_r.trim     <= RST_TRIM;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from state
    assign regRdData       = st_r.rdData;
    assign countdownRepeat = st_r.cdRepeat;
    assign secondTick      = st_r.secTick;
    assign squareWaveOut   = st_r.sqOut;
    assign irqPinOut       = 1'b0 & st_r.irqOe;             // Open drain: only ever pulls low
    assign irqPinOe        = st_r.irqOe;
endmodule : rtcc_irq_square_wave_out_trim

// ### src/rtcc_pkg.sv
// Notes on behaviour
// - Alarm match sets alarm flag until written
// - Control write ANDs written bits into flags
// - Alarm enable gates alarm flag onto interrupt
// - Minute pulses last one sixty-fourth second
// - Periodic timers aligned to seconds counter
// - Half-minute wins; minute alone per minute
// - Any timer trigger sets timer flag
// - Pulse mode: pulse per event, countdown repeats
// - Level mode: interrupt follows flag, countdown halts
// - Select picks 32768 down to 1 Hz
// - Select 111 or gate pin low: output low
// - Stop holds 4096 Hz and below low
// - Divided outputs have 50:50 duty
// - Trim: mode bit7, signed value bits6-0
// - Step 4.34 ppm normal, 4.069 fast
// - Correction moves prescaler, not oscillator
// - Correction enable: pulse per correction applied
// - Normal: every second hour, one per minute
// - Fast: every four minutes, excess in second 59
// - Normal correction only below 64 Hz
// - Fast correction also hits 64 Hz source
package rtcc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_CTRL1   = 8'h00;
    localparam logic [7:0] ADDR_CTRL2   = 8'h01;
    localparam logic [7:0] ADDR_TRIM    = 8'h02;
    localparam logic [7:0] ADDR_TMODE   = 8'h11;
    // Field positions
    localparam int CTRL1_STOP_BIT  = 5;
    localparam int CTRL1_CIE_BIT   = 2;
    localparam int CTRL2_AIE_BIT   = 7;
    localparam int CTRL2_AF_BIT    = 6;
    localparam int CTRL2_MI_BIT    = 5;
    localparam int CTRL2_HMI_BIT   = 4;
    localparam int CTRL2_TF_BIT    = 3;
    localparam int TMODE_TIE_BIT   = 1;
    localparam int TMODE_TP_BIT    = 0;
    localparam int TRIM_MODE_BIT   = 7;
    // Reset values
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_TRIM  = 8'h00;
    // Clock-out select codes
    localparam logic [2:0] COF_32768 = 3'h0;
    localparam logic [2:0] COF_16384 = 3'h1;
    localparam logic [2:0] COF_8192  = 3'h2;
    localparam logic [2:0] COF_4096  = 3'h3;
    localparam logic [2:0] COF_2048  = 3'h4;
    localparam logic [2:0] COF_1024  = 3'h5;
    localparam logic [2:0] COF_1HZ   = 3'h6;
    localparam logic [2:0] COF_OFF   = 3'h7;
    // Timing
    localparam int CLK_HZ        = 200_000_000;
    localparam int XTAL_HZ       = 32768;
    localparam int HALF_XTAL_CYC = CLK_HZ / (2 * XTAL_HZ);
    localparam int PRE_BITS      = 15;
    localparam logic [9:0] IND_NORMAL_TICKS = 10'h200;  // 1/64 s in crystal ticks
    localparam logic [9:0] IND_FAST_TICKS   = 10'h020;  // 1/1024 s in crystal ticks
    // One step: 4.34 ppm of 2 h and 4.069 ppm of 4 min, in crystal ticks
    localparam logic [15:0] STEP_NORMAL = 16'h0400;
    localparam logic [15:0] STEP_FAST   = 16'h0020;
    localparam logic [5:0] SEC_LAST  = 6'h3B;
    localparam logic [5:0] SEC_HALF  = 6'h1E;
    localparam logic [6:0] MIN_LAST  = 7'h77;           // two-hour window
endpackage : rtcc_pkg

// ### sim/rtcc_chk.sv
`timescale 1ns/100ps
module rtcc_chk
    import rtcc_pkg::*;
(
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       regWrEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [7:0] regRdData,
    input wire logic       alarmMatch,
    input wire logic       countdownExpire,
    input wire logic       countdownRepeat,
    input wire logic       secondTick,
    input wire logic       squareWaveGatePin,
    input wire logic       squareWaveOut,
    input wire logic       irqPinOe
);
    logic       aieS;
    logic       stopS;
    logic       tpS;
    logic [2:0] cofS;
    // Shadow of the gating bits; moves on the same edge as the real registers
    always_ff @(posedge clk) begin
        if (srst) begin
            {aieS, stopS, tpS, cofS} <= 6'h00;
        end else if (regWrEn) begin
            if (regAddr == ADDR_CTRL1) stopS <= regWrData[CTRL1_STOP_BIT];
            if (regAddr == ADDR_TMODE) tpS <= regWrData[TMODE_TP_BIT];
            if (regAddr == ADDR_CTRL2) {aieS, cofS} <= {regWrData[CTRL2_AIE_BIT], regWrData[2:0]};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    // A match in either cycle would set the flag again, so both are excluded
    sequence s_clr;
        regWrEn && regAddr == ADDR_CTRL2 && !regWrData[CTRL2_AF_BIT] && !alarmMatch
        ##1 regAddr == ADDR_CTRL2 && !alarmMatch;
    endsequence
    sequence s_trim;
        regWrEn && regAddr == ADDR_TRIM ##1 regAddr == ADDR_TRIM && !regWrEn;
    endsequence
    property p_clear; s_clr |=> !regRdData[CTRL2_AF_BIT]; endproperty
    property p_trim; s_trim |=> regRdData == $past(regWrData, 2); endproperty
    // Flag lands one edge after the match and the pin one edge later still
    sequence s_alarm;
        alarmMatch && aieS && !regWrEn ##1 !regWrEn;
    endsequence
    property p_alarm; s_alarm |-> ##2 irqPinOe; endproperty
    property p_nosec; stopS [*2] |-> !secondTick; endproperty
    property p_repeat;
        regWrEn && regAddr == ADDR_TMODE |-> ##2 countdownRepeat == $past(regWrData[TMODE_TP_BIT], 2);
    endproperty
    property p_stop; (stopS && cofS inside {[3'h3:3'h6]}) [*3] |-> !squareWaveOut; endproperty
    property p_off; (cofS == COF_OFF) [*3] |-> !squareWaveOut; endproperty
    property p_gate; (!squareWaveGatePin) [*3] |-> !squareWaveOut; endproperty
    property p_tpulse; countdownExpire && tpS |-> ##3 irqPinOe [*8]; endproperty
    a_clear: assert property (p_clear) else $error("alarm flag survived a clearing write");
    a_trim: assert property (p_trim) else $error("trim readback differs");
    a_alarm: assert property (p_alarm) else $error("enabled alarm gave no interrupt");
    a_repeat: assert property (p_repeat) else $error("repeat output wrong");
    a_stop: assert property (p_stop) else $error("stopped low clock still toggles");
    a_off: assert property (p_off) else $error("disabled clock output not low");
    a_gate: assert property (p_gate) else $error("gated clock output not low");
    a_tpulse: assert property (p_tpulse) else $error("pulse mode event gave no pulse");
    a_nosec: assert property (p_nosec) else $error("second tick while stopped");
endmodule : rtcc_chk

bind rtcc_irq_square_wave_out_trim rtcc_chk rtcc_chk_inst (.clk, .srst, .regWrEn, .regAddr, .regWrData, .regRdData,
    .alarmMatch, .countdownExpire, .countdownRepeat, .secondTick, .squareWaveGatePin, .squareWaveOut, .irqPinOe);

// ### sim/rtcc_host_model.sv
`timescale 1ns/100ps
module rtcc_host_model (
    input  wire logic irqPinOut,
    input  wire logic irqPinOe,
    output logic      intLine,
    output int        intCount
);
    // Open-drain line with the host pull-up: a released pin reads high
    assign intLine = irqPinOe ? irqPinOut : 1'b1;
    // Counts fresh assertions, so a held level is told apart from a new event
    always @(negedge intLine) intCount++;
    // The host leaves the periodic enables off, so fast trim never meets them
endmodule : rtcc_host_model

// ### sim/rtcc_irq_square_wave_out_trim_test.sv
`timescale 1ns/100ps
module rtcc_irq_square_wave_out_trim_test
    import rtcc_pkg::*;
;
    localparam int HC = 4;
    logic       clk;
    logic       srst;
    logic       regWrEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData;
    logic       alarmMatch;
    logic       countdownExpire;
    logic       countdownRepeat;
    logic       squareWaveGatePin;
    logic       squareWaveOut;
    logic       irqPinOut;
    logic       irqPinOe;
    logic       intLine;
    int         intCount;
    int         fails;
    int         checks;
    int         n;
    // Rows: select, stop, gate pin, half period in cycles at HC=4 (0 = held low)
    int rows [14][4] = '{'{0,0,1,4}, '{1,0,1,8}, '{2,0,1,16}, '{3,0,1,32}, '{4,0,1,64}, '{5,0,1,128},
        '{1,1,1,8}, '{2,1,1,16}, '{3,1,1,0}, '{5,1,1,0}, '{6,1,1,0}, '{7,0,1,0}, '{0,0,0,0}, '{4,0,0,0}};
    logic [7:0] regs [5] = '{ADDR_CTRL1, ADDR_CTRL2, ADDR_TRIM, ADDR_TMODE, 8'h05};
    rtcc_irq_square_wave_out_trim #(.HALF_CYC(HC)) rtcc_irq_square_wave_out_trim_inst (.clk, .srst, .regWrEn, .regAddr,
        .regWrData, .regRdData, .alarmMatch, .countdownExpire, .countdownRepeat, .secondTick(),
        .squareWaveGatePin, .squareWaveOut, .irqPinOut, .irqPinOe);
    rtcc_host_model rtcc_host_model_inst (.irqPinOut, .irqPinOe, .intLine, .intCount);
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    task automatic check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val
    task automatic check_cnt(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            fails++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt
    // Bus tasks start on a falling edge; the extra edge keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
        @(negedge clk);
        regWrEn = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        repeat (2) @(negedge clk);
        check_val(what, exp, regRdData);
    endtask : rdchk
    task automatic strobe(input logic tmr);
        {countdownExpire, alarmMatch} = {tmr, !tmr};
        @(negedge clk);
        {countdownExpire, alarmMatch} = 2'b00;
        @(negedge clk);
    endtask : strobe
    task automatic check_int(input logic exp);
        repeat (2) @(negedge clk);
        check_val("int line", {7'h00, exp}, {7'h00, intLine});
    endtask : check_int
    // Cycles until the square wave changes; a stuck output ends the run
    task automatic gap(output int c);
        logic last;
        last = squareWaveOut;
        c = 0;
        while (squareWaveOut === last) begin
            @(negedge clk);
            c++;
            if (c > 1000) begin
                fails++;
                close_out();
            end
        end
    endtask : gap
    task automatic measure(input int half);
        int c;
        c = 0;
        repeat (8) @(negedge clk);
        if (half == 0) begin
            repeat (300) @(negedge clk) c += (squareWaveOut !== 1'b0);
            check_cnt("held low", 0, c);
        end else begin
            gap(c);
            repeat (2) begin
                gap(c);
                check_cnt("half period", half, c);
            end
        end
    endtask : measure
    // Length of one interrupt assertion, bounded both before and during it
    task automatic low_time(output int c);
        c = 0;
        while (intLine !== 1'b0 && c < 20) @(negedge clk) c++;
        c = 0;
        while (intLine === 1'b0 && c < 6000) @(negedge clk) c++;
    endtask : low_time
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Main sequence: table rows first, then the hand-written cases
    initial begin
        {srst, regWrEn, regAddr, regWrData, alarmMatch, countdownExpire} = {1'b1, 19'h00000};
        squareWaveGatePin = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        foreach (rows[i]) begin
            squareWaveGatePin = rows[i][2][0];
            wr(ADDR_CTRL1, 8'(rows[i][1] << CTRL1_STOP_BIT));
            wr(ADDR_CTRL2, 8'(rows[i][0]));
            measure(rows[i][3]);
        end
        squareWaveGatePin = 1'b1;
        wr(ADDR_TRIM, 8'hC0);
        rdchk("trim", ADDR_TRIM, 8'hC0);
        wr(ADDR_TRIM, 8'h3F);
        rdchk("trim", ADDR_TRIM, 8'h3F);
        srst = 1'b1;
        repeat (16) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        foreach (regs[i]) rdchk("reset value", regs[i], 8'h00);
        measure(HC);
        wr(ADDR_CTRL2, 8'h80);
        strobe(1'b0);
        rdchk("ctrl2", ADDR_CTRL2, 8'hC0);
        check_int(1'b0);
        wr(ADDR_CTRL2, 8'hC0);
        rdchk("ctrl2", ADDR_CTRL2, 8'hC0);
        wr(ADDR_CTRL2, 8'h80);
        rdchk("ctrl2", ADDR_CTRL2, 8'h80);
        check_int(1'b1);
        fork
            wr(ADDR_CTRL2, 8'h80);
            strobe(1'b0);
        join
        rdchk("ctrl2", ADDR_CTRL2, 8'hC0);
        wr(ADDR_CTRL2, 8'h00);
        strobe(1'b0);
        rdchk("ctrl2", ADDR_CTRL2, 8'h40);
        check_int(1'b1);
        wr(ADDR_CTRL2, 8'h00);
        wr(ADDR_TMODE, 8'h02);
        check_val("repeat", 8'h00, {7'h00, countdownRepeat});
        strobe(1'b1);
        rdchk("ctrl2", ADDR_CTRL2, 8'h08);
        check_int(1'b0);
        n = intCount;
        strobe(1'b1);
        check_int(1'b0);
        check_cnt("int falls", n, intCount);
        wr(ADDR_CTRL2, 8'h00);
        check_int(1'b1);
        wr(ADDR_TMODE, 8'h01);
        rdchk("tmode", ADDR_TMODE, 8'h01);
        check_val("repeat", 8'h01, {7'h00, countdownRepeat});
        repeat (2) begin
            n = intCount;
            strobe(1'b1);
            low_time(n);
            check_val("pulse width", 8'h01, {7'h00, (n >= 16 * 256 - 8 && n <= 16 * 256 + 8)});
        end
        rdchk("ctrl2", ADDR_CTRL2, 8'h08);
        close_out();
    end
endmodule : rtcc_irq_square_wave_out_trim_test
